// ===== serial_flash_regs.svh
`ifndef SERIAL_FLASH_REGS_SVH
`define SERIAL_FLASH_REGS_SVH

// ==========================================
// clock and timing
`define CLK_PERIOD_NS 8
`define TIMER_W 24
`define PULSE_W 11
`define RESET_PULSE_MIN_US 10
`define RESET_PULSE_MIN_CYC ((`RESET_PULSE_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_TO_SELECT_DELAY_US 10
`define RESET_TO_SELECT_DELAY_CYC ((`RESET_TO_SELECT_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_DECODE_US 40
`define REC_READ_US 35
`define REC_PROGRAM_US 310
`define REC_SECTOR_MS 12
`define REC_BLOCK_MS 25
`define REC_CHIP_MS 100
`define REC_STATUS_MS 40
`define US_TO_CYC(t) ((t * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MS_TO_CYC(t) ((t * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================
// register offsets, fields, reset values
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define CTRL_WEL_BIT 0
`define CTRL_ADDR4_BIT 1
`define CTRL_SRAM_LOCK_BIT 2
`define CTRL_DEEP_PD_BIT 3
`define ST_READY_BIT 0
`define ST_HELD_BIT 1
`define ST_RECOVER_BIT 2
`define ST_POWERUP_BIT 3
`define ST_WIP_BIT 4
`define ST_KIND_LSB 5
`define VOLATILE_RESET 5'h00
`endif

// ===== flash_reset_pkg.sv
package flash_reset_pkg;
  // ==========================================
  // operation the core reports as in progress
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_DECODE,
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_BLOCK_ERASE,
    OP_CHIP_ERASE,
    OP_STATUS_WRITE
  } op_kind_t;

  typedef enum logic [2:0] {
    ST_POR,
    ST_POWERUP,
    ST_READY,
    ST_PIN_LOW,
    ST_RESET_HELD,
    ST_RECOVERY
  } seq_state_t;

  // volatile device bits, all clear at power-on
  typedef struct packed {
    logic deep_pd;
    logic sram_lock;
    logic addr4;
    logic write_in_progress;
    logic write_enable_latch;
  } volatile_bits_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// ===== recovery_timer.sv
`include "serial_flash_regs.svh"
module recovery_timer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [`TIMER_W-1:0] load_val_in,
  input wire logic run_in,
  output logic expired_out,
  output logic [`TIMER_W-1:0] count_out
);
  logic [`TIMER_W-1:0] cnt_q;
  logic [`TIMER_W-1:0] cnt_d;

  // ==========================================
  // down counter; load takes n-1 so a run lasts n cycles
  always_comb begin
    cnt_d = cnt_q;
    if (load_in) begin
      cnt_d = load_val_in - `TIMER_W'(1);
    end else if (run_in && cnt_q != '0) begin
      cnt_d = cnt_q - `TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired_out = (cnt_q == '0);
  assign count_out = cnt_q;
endmodule

// ===== reset_sequencer.sv
// Decided for this implementation: the placing of the registers and the strobed register port.
`include "serial_flash_regs.svh"
module reset_sequencer #(
  parameter logic [`TIMER_W-1:0] DECODE_REC_CYC = `TIMER_W'(`US_TO_CYC(`REC_DECODE_US)),
  parameter logic [`TIMER_W-1:0] READ_REC_CYC = `TIMER_W'(`US_TO_CYC(`REC_READ_US)),
  parameter logic [`TIMER_W-1:0] PROGRAM_REC_CYC = `TIMER_W'(`US_TO_CYC(`REC_PROGRAM_US)),
  parameter logic [`TIMER_W-1:0] SECTOR_REC_CYC = `TIMER_W'(`MS_TO_CYC(`REC_SECTOR_MS)),
  parameter logic [`TIMER_W-1:0] BLOCK_REC_CYC = `TIMER_W'(`MS_TO_CYC(`REC_BLOCK_MS)),
  parameter logic [`TIMER_W-1:0] CHIP_REC_CYC = `TIMER_W'(`MS_TO_CYC(`REC_CHIP_MS)),
  parameter logic [`TIMER_W-1:0] STATUS_REC_CYC = `TIMER_W'(`MS_TO_CYC(`REC_STATUS_MS))
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic reset_pin_n_in,
  input wire logic cs_n_in,
  input wire logic supply_ok_in,
  input wire flash_reset_pkg::op_kind_t op_kind_in,
  input wire flash_reset_pkg::reg_req_t reg_req_in,
  output logic [31:0] reg_rdata_out,
  output logic cs_gated_n_out,
  output logic core_reset_out,
  output logic abort_op_out,
  output logic so_oe_out,
  output logic low_power_out,
  output logic busy_out,
  output flash_reset_pkg::volatile_bits_t volatile_out
);
  import flash_reset_pkg::*;

  localparam logic [`PULSE_W-1:0] PULSE_MIN = `PULSE_W'(`RESET_PULSE_MIN_CYC);

  // ==========================================
  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================
  // recovery length per interrupted operation
  function automatic logic [`TIMER_W-1:0] rec_cycles(input op_kind_t k);
    logic [`TIMER_W-1:0] c;
    c = READ_REC_CYC;
    case (k)
      OP_DECODE: c = DECODE_REC_CYC;
      OP_PROGRAM: c = PROGRAM_REC_CYC;
      OP_SECTOR_ERASE: c = SECTOR_REC_CYC;
      OP_BLOCK_ERASE: c = BLOCK_REC_CYC;
      OP_CHIP_ERASE: c = CHIP_REC_CYC;
      OP_STATUS_WRITE: c = STATUS_REC_CYC;
      default: c = READ_REC_CYC;
    endcase
    return c;
  endfunction

  function automatic logic is_write_op(input op_kind_t k);
    return (k == OP_PROGRAM) || (k == OP_SECTOR_ERASE) || (k == OP_BLOCK_ERASE) ||
           (k == OP_CHIP_ERASE) || (k == OP_STATUS_WRITE);
  endfunction

  // ==========================================
  // sequencer state
  seq_state_t state_q, state_d;
  op_kind_t kind_q, kind_d;
  logic [`PULSE_W-1:0] pulse_cnt_q, pulse_cnt_d;
  logic abort_q, abort_d;
  logic timer_load;
  logic [`TIMER_W-1:0] timer_val;
  logic timer_expired;
  logic [`TIMER_W-1:0] timer_count;

  recovery_timer u_timer (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .load_in(timer_load),
    .load_val_in(timer_val),
    .run_in((state_q == ST_RECOVERY) || (state_q == ST_POWERUP)),
    .expired_out(timer_expired),
    .count_out(timer_count)
  );

  // supply loss overrides everything, even a recovery in flight
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    pulse_cnt_d = pulse_cnt_q;
    abort_d = 1'b0;
    timer_load = 1'b0;
    timer_val = READ_REC_CYC;
    if (!supply_ok_in) begin
      state_d = ST_POR;
    end else begin
      case (state_q)
        ST_POR: begin
          state_d = ST_POWERUP;
          kind_d = OP_READ; // power-on uses the read recovery
          timer_load = 1'b1;
          timer_val = READ_REC_CYC;
        end
        ST_POWERUP, ST_RECOVERY: begin
          if (!reset_pin_n_in) begin
            state_d = ST_PIN_LOW; // kind kept: earlier recovery still owed
            pulse_cnt_d = '0;
          end else if (timer_expired) begin
            state_d = ST_READY;
          end
        end
        ST_READY: begin
          if (!reset_pin_n_in) begin
            state_d = ST_PIN_LOW;
            kind_d = op_kind_in;
            pulse_cnt_d = '0;
          end
        end
        ST_PIN_LOW: begin
          if (reset_pin_n_in) begin
            // a short pulse does no reset; restart the recovery or go back to ready
            state_d = (kind_q == op_kind_in) ? ST_READY : ST_RECOVERY;
            timer_load = (kind_q != op_kind_in);
            timer_val = rec_cycles(kind_q);
          end else if (pulse_cnt_q == PULSE_MIN - `PULSE_W'(1)) begin
            state_d = ST_RESET_HELD;
            abort_d = is_write_op(kind_q);
          end else begin
            pulse_cnt_d = pulse_cnt_q + `PULSE_W'(1);
          end
        end
        ST_RESET_HELD: begin
          if (reset_pin_n_in) begin
            state_d = ST_RECOVERY;
            timer_load = 1'b1;
            timer_val = rec_cycles(kind_q);
          end
        end
        default: begin
          state_d = ST_POR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_POR;
      kind_q <= OP_IDLE;
      pulse_cnt_q <= '0;
      abort_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      pulse_cnt_q <= pulse_cnt_d;
      abort_q <= abort_d;
    end
  end

  // ==========================================
  // volatile bits and register bus
  volatile_bits_t vol_q, vol_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready;
  logic full_reset;

  assign ready = (state_q == ST_READY);
  // recovery after a full pulse and power-up start from defaults
  assign full_reset = (state_q == ST_POR) || (state_q == ST_RESET_HELD);

  // writes are dropped unless ready: the core is held then, except in ST_PIN_LOW, before the pulse is long enough to reset
  always_comb begin
    vol_d = vol_q;
    if (full_reset) begin
      vol_d = `VOLATILE_RESET;
    end else begin
      vol_d.write_in_progress = ready && is_write_op(op_kind_in);
      if (ready && reg_req_in.wr && reg_req_in.addr == `CTRL_OFFSET) begin
        vol_d.write_enable_latch = reg_req_in.wdata[`CTRL_WEL_BIT];
        vol_d.addr4 = reg_req_in.wdata[`CTRL_ADDR4_BIT];
        vol_d.sram_lock = reg_req_in.wdata[`CTRL_SRAM_LOCK_BIT];
        vol_d.deep_pd = reg_req_in.wdata[`CTRL_DEEP_PD_BIT];
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_comb begin
    rdata_d = 32'h0;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        `CTRL_OFFSET: begin
          rdata_d[`CTRL_WEL_BIT] = vol_q.write_enable_latch;
          rdata_d[`CTRL_ADDR4_BIT] = vol_q.addr4;
          rdata_d[`CTRL_SRAM_LOCK_BIT] = vol_q.sram_lock;
          rdata_d[`CTRL_DEEP_PD_BIT] = vol_q.deep_pd;
        end
        `STATUS_OFFSET: begin
          rdata_d[`ST_READY_BIT] = ready;
          rdata_d[`ST_HELD_BIT] = (state_q == ST_RESET_HELD);
          rdata_d[`ST_RECOVER_BIT] = (state_q == ST_RECOVERY);
          rdata_d[`ST_POWERUP_BIT] = (state_q == ST_POWERUP);
          rdata_d[`ST_WIP_BIT] = vol_q.write_in_progress;
          rdata_d[`ST_KIND_LSB +: 3] = kind_q;
        end
        default: begin
          rdata_d = 32'h0; // unmapped reads zero
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      vol_q <= `VOLATILE_RESET;
      rdata_q <= 32'h0;
    end else begin
      vol_q <= vol_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // pin side outputs
  logic so_oe_q, so_oe_d;
  logic core_rst_q, core_rst_d;
  logic low_pwr_q, low_pwr_d;

  always_comb begin
    so_oe_d = ready && reset_pin_n_in && supply_ok_in;
    core_rst_d = (state_d != ST_READY) && (state_d != ST_PIN_LOW);
    low_pwr_d = (state_d == ST_RESET_HELD) || (state_d == ST_PIN_LOW) || vol_d.deep_pd;
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      so_oe_q <= 1'b0;
      core_rst_q <= 1'b1;
      low_pwr_q <= 1'b0;
    end else begin
      so_oe_q <= so_oe_d;
      core_rst_q <= core_rst_d;
      low_pwr_q <= low_pwr_d;
    end
  end

  // select passes only while ready; cheap gate, no latency
  assign cs_gated_n_out = cs_n_in || !ready;
  assign busy_out = !ready;
  assign so_oe_out = so_oe_q;
  assign core_reset_out = core_rst_q;
  assign low_power_out = low_pwr_q;
  assign abort_op_out = abort_q;
  assign volatile_out = vol_q;
  assign reg_rdata_out = rdata_q;

  // ==========================================
  // checks, with independent cycle counters
  logic [`PULSE_W-1:0] low_run_q;
  logic [`TIMER_W-1:0] rec_run_q;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      low_run_q <= '0;
      rec_run_q <= '0;
    end else begin
      low_run_q <= reset_pin_n_in ? '0 : ((low_run_q == '1) ? low_run_q : low_run_q + `PULSE_W'(1));
      rec_run_q <= (state_q == ST_RECOVERY) ? rec_run_q + `TIMER_W'(1) : '0;
    end
  end

  property p_pulse_min;
    @(posedge mclk_in) disable iff (!rst_n)
    (state_q == ST_PIN_LOW && state_d == ST_RESET_HELD) |-> (low_run_q >= PULSE_MIN - `PULSE_W'(1));
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("reset taken on short pulse");

  property p_defaults;
    @(posedge mclk_in) disable iff (!rst_n)
    (state_q == ST_RESET_HELD && supply_ok_in) ##1 (state_q == ST_RECOVERY) |->
      (vol_q == `VOLATILE_RESET) && !so_oe_q;
  endproperty
  a_defaults: assert property (p_defaults) else $error("volatile bits not at default after reset");

  property p_abort;
    @(posedge mclk_in) disable iff (!rst_n)
    $rose(state_q == ST_RESET_HELD) |-> (abort_op_out == is_write_op(kind_q)) ##1 !abort_op_out;
  endproperty
  a_abort: assert property (p_abort) else $error("abort pulse wrong");

  property p_so_hiz;
    @(posedge mclk_in) disable iff (!rst_n)
    !reset_pin_n_in |=> !so_oe_out && (state_q != ST_RESET_HELD || low_power_out);
  endproperty
  a_so_hiz: assert property (p_so_hiz) else $error("output driven during reset");

  property p_rec_short;
    @(posedge mclk_in) disable iff (!rst_n)
    (state_q == ST_RECOVERY && state_d == ST_READY && (kind_q == OP_DECODE || kind_q == OP_READ)) |->
      (rec_run_q + `TIMER_W'(1) >= rec_cycles(kind_q));
  endproperty
  a_rec_short: assert property (p_rec_short) else $error("decode or read recovery too short");

  property p_rec_program;
    @(posedge mclk_in) disable iff (!rst_n)
    (state_q == ST_RECOVERY && state_d == ST_READY && (kind_q == OP_PROGRAM || kind_q == OP_SECTOR_ERASE)) |->
      (rec_run_q + `TIMER_W'(1) >= ((kind_q == OP_PROGRAM) ? PROGRAM_REC_CYC : SECTOR_REC_CYC));
  endproperty
  a_rec_program: assert property (p_rec_program) else $error("program recovery too short");

  property p_rec_erase;
    @(posedge mclk_in) disable iff (!rst_n)
    (state_q == ST_RECOVERY && state_d == ST_READY && kind_q inside {OP_BLOCK_ERASE, OP_CHIP_ERASE,
      OP_STATUS_WRITE}) |-> (rec_run_q + `TIMER_W'(1) >= rec_cycles(kind_q)) && (rec_run_q >= STATUS_REC_CYC / 2);
  endproperty
  a_rec_erase: assert property (p_rec_erase) else $error("erase recovery too short");

  property p_powerup;
    @(posedge mclk_in) disable iff (!rst_n)
    (state_q == ST_POR && supply_ok_in) |=> (state_q == ST_POWERUP) && !vol_q.deep_pd && !vol_q.write_enable_latch;
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up state wrong");

  property p_lockout;
    @(posedge mclk_in) disable iff (!rst_n)
    !supply_ok_in |=> (state_q == ST_POR) && core_reset_out && cs_gated_n_out ##1 core_reset_out;
  endproperty
  a_lockout: assert property (p_lockout) else $error("logic active below lockout threshold");

  property p_busy_cs;
    @(posedge mclk_in) disable iff (!rst_n)
    (state_q == ST_RECOVERY && !timer_expired) |-> cs_gated_n_out && busy_out && (timer_count != '0);
  endproperty
  a_busy_cs: assert property (p_busy_cs) else $error("select passed during recovery");
endmodule

// ===== flash_host_model.sv
`include "serial_flash_regs.svh"
module flash_host_model (
  input wire logic mclk_in,
  input wire logic busy_in,
  input wire logic cs_gated_n_in,
  output logic reset_pin_n_out,
  output logic cs_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // pin drive
  // both pins idle high; no select until a test asks for one
  initial begin
    reset_pin_n_out = 1'b1;
    cs_n_out = 1'b1;
  end

  // pin low for n cycles; below the minimum only when a test asks
  task automatic hold_low(input int n);
    @(posedge mclk_in);
    reset_pin_n_out <= 1'b0;
    repeat (n) @(posedge mclk_in);
  endtask

  // release, no select for the full delay, then wait out the recovery busy time
  task automatic release_wait();
    @(posedge mclk_in);
    reset_pin_n_out <= 1'b1;
    repeat (`RESET_TO_SELECT_DELAY_CYC) @(posedge mclk_in);
    // bounded, so a stuck busy cannot hang the host
    for (int n = 0; n < 40000 && busy_in !== 1'b0; n++) begin
      @(posedge mclk_in);
    end
  endtask

  // one cycle of select, reporting what the core was handed mid-cycle
  task automatic select(output logic gated_n);
    @(posedge mclk_in);
    cs_n_out <= 1'b0;
    @(negedge mclk_in);
    gated_n = cs_gated_n_in;
    @(posedge mclk_in);
    cs_n_out <= 1'b1;
  endtask
endmodule

// ===== testbench.sv
`include "serial_flash_regs.svh"
module testbench;
  import flash_reset_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // signals and settings
  // short recoveries at full length; the erase and status write counts are shrunk to keep the run short
  localparam int REC[8] = '{0, `US_TO_CYC(`REC_DECODE_US), `US_TO_CYC(`REC_READ_US),
    `US_TO_CYC(`REC_PROGRAM_US), 12, 14, 16, 15};
  localparam int LIMIT = 90000;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic supply_ok_in = 1'b1;
  op_kind_t op_kind_in = OP_IDLE;
  reg_req_t req = '0;
  logic reset_pin_n, cs_n, cs_gated_n_out, core_reset_out, abort_op_out;
  logic so_oe_out, low_power_out, busy_out, gated;
  logic [31:0] reg_rdata_out, rd;
  volatile_bits_t volatile_out;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int rec_cnt = 0;
  int abort_cnt = 0;

  always #4 mclk_in = ~mclk_in;

  reset_sequencer #(.SECTOR_REC_CYC(24'd12), .BLOCK_REC_CYC(24'd14), .CHIP_REC_CYC(24'd16),
    .STATUS_REC_CYC(24'd15)) DUT (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reset_pin_n_in(reset_pin_n), .cs_n_in(cs_n),
    .supply_ok_in(supply_ok_in), .op_kind_in(op_kind_in), .reg_req_in(req),
    .reg_rdata_out(reg_rdata_out), .cs_gated_n_out(cs_gated_n_out),
    .core_reset_out(core_reset_out), .abort_op_out(abort_op_out), .so_oe_out(so_oe_out),
    .low_power_out(low_power_out), .busy_out(busy_out), .volatile_out(volatile_out));

  flash_host_model HOST (
    .mclk_in(mclk_in), .busy_in(busy_out), .cs_gated_n_in(cs_gated_n_out),
    .reset_pin_n_out(reset_pin_n), .cs_n_out(cs_n));

  // ==========================================
  // monitors
  // busy cycles since the last pin release or supply return; aborts seen
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (!rst_n_in || !reset_pin_n || !supply_ok_in) rec_cnt <= 0;
    else if (busy_out) rec_cnt <= rec_cnt + 1;
    if (abort_op_out === 1'b1) abort_cnt <= abort_cnt + 1;
    if (cyc == LIMIT) begin
      err_total++;
      end_sim();
    end
  end

  // ==========================================
  // comparisons and bus cycles
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_range(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    req.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    req.rd <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // bounded wait for the end of busy
  task automatic wait_ready();
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 40000) begin
      @(posedge mclk_in);
      n++;
    end
    #1 chk_bit("busy", 1'b0, busy_out);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================
  // tests
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    // power-up: standby, read-length recovery, latch clear
    wait_ready();
    chk_range("powerup busy", REC[2], REC[2] + 4, rec_cnt);
    chk_word("powerup bits", 32'h0, {27'h0, volatile_out});
    chk_bit("powerup low power", 1'b0, low_power_out);
    reg_rd(`STATUS_OFFSET, rd);
    chk_word("powerup status", {24'h0, 3'(OP_READ), 5'b00001}, rd);
    reg_wr(`CTRL_OFFSET, 32'h0000000f);
    #1 chk_bit("deep pd power", 1'b1, low_power_out);
    reg_rd(`CTRL_OFFSET, rd);
    chk_word("ctrl readback", 32'h0000000f, rd);
    reg_rd(8'h40, rd);
    chk_word("unmapped", 32'h0, rd);
    $display("test powerup done");

    // full pulse during each operation kind except OP_IDLE
    for (int k = 1; k < 8; k++) begin
      reg_wr(`CTRL_OFFSET, 32'h00000007);
      op_kind_in <= op_kind_t'(k);
      abort_cnt = 0;
      HOST.hold_low(`RESET_PULSE_MIN_CYC + 10);
      #1 chk_bit("output enable held", 1'b0, so_oe_out);
      chk_bit("low power held", 1'b1, low_power_out);
      chk_bit("core reset held", 1'b1, core_reset_out);
      chk_word("abort count", (k >= 3) ? 32'h1 : 32'h0, 32'(abort_cnt));
      chk_word("bits held", 32'h0, {27'h0, volatile_out});
      HOST.select(gated);
      chk_bit("select gated", 1'b1, gated);
      reg_wr(`CTRL_OFFSET, 32'h00000003);
      op_kind_in <= OP_IDLE;
      HOST.release_wait();
      wait_ready();
      chk_range("recovery busy", REC[k], REC[k] + 4, rec_cnt);
      chk_bit("output enable after", 1'b1, so_oe_out);
      chk_word("bits after", 32'h0, {27'h0, volatile_out});
      chk_bit("core reset after", 1'b0, core_reset_out);
      reg_rd(`STATUS_OFFSET, rd);
      chk_word("status after", {24'h0, 3'(k), 5'b00001}, rd);
      HOST.select(gated);
      chk_bit("select passed", 1'b0, gated);
      $display("test pulse kind %0d done", k);
    end

    // a short pulse leaves the bits alone
    reg_wr(`CTRL_OFFSET, 32'h00000003);
    HOST.hold_low(100);
    HOST.release_wait();
    chk_word("bits short pulse", 32'h5, {27'h0, volatile_out});
    $display("test short pulse done");

    // supply lockout holds reset and drops writes
    reg_wr(`CTRL_OFFSET, 32'h00000007);
    @(posedge mclk_in);
    supply_ok_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 chk_bit("core reset lockout", 1'b1, core_reset_out);
    chk_bit("busy lockout", 1'b1, busy_out);
    reg_wr(`CTRL_OFFSET, 32'h00000007);
    #1 chk_word("bits lockout", 32'h0, {27'h0, volatile_out});
    @(posedge mclk_in);
    supply_ok_in <= 1'b1;
    wait_ready();
    chk_range("lockout recovery", REC[2], REC[2] + 4, rec_cnt);
    chk_word("bits return", 32'h0, {27'h0, volatile_out});
    $display("test lockout done");
    end_sim();
  end
endmodule
